// *** hdl/rsm_pkg.sv ***
// constants, types and register map of the reset sequencer
// assumes a 40 MHz cpu clock and an 8-bit register port
package rsm_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 40;
  // minimum pin output pulse after a watchdog underflow
  localparam int WDG_PULSE_NS = 30000;
  localparam int WDG_PULSE_CYC = (WDG_PULSE_NS * CLK_MHZ + 999) / 1000;
  // frequency multiplier start-up delay
  localparam int PLL_STARTUP_US = 100;
  localparam int PLL_STARTUP_CYC = PLL_STARTUP_US * CLK_MHZ;
  localparam int PULSE_W = 16;
  localparam int DELAY_SHORT = 256;
  localparam int DELAY_LONG = 4096;
  localparam int DLY_W = 13;
  // cycles the pin echo needs to clear the synchronisers
  localparam int GUARD_CYC = 6;
  localparam int GUARD_W = 3;

  // ==========================================================
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RC_TRIM = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ICSR = 8'h01;
  localparam logic [DATA_W-1:0] RC_TRIM_RST = 8'hFF;
  localparam logic [1:0] ICSR_TRIM_RST = 2'h3;
  localparam int ICSR_TRIM_HI = 6;
  localparam int ICSR_TRIM_LO = 5;
  localparam int ICSR_WATCHDOG_RESET_FLAG = 4;
  localparam int ICSR_LOCKED = 3;
  localparam int ICSR_LOW_SUPPLY_RESET_FLAG = 2;
  localparam int ICSR_AUX_SUPPLY_LOW_FLAG = 1;
  localparam int ICSR_AUX_SUPPLY_IRQ_ENABLE = 0;

  // ==========================================================
  // vector and clock source codes
  localparam logic [15:0] VEC_ADDR_LO = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_HI = 16'hFFFF;
  localparam logic [1:0] CLKSRC_RC = 2'h0;
  localparam logic [1:0] CLKSRC_EXT = 2'h1;
  localparam logic [1:0] CLKSRC_XTAL = 2'h2;

  // synchroniser bit positions
  localparam int SY_PIN = 0;
  localparam int SY_LATCH = 1;
  localparam int SY_LVD = 2;
  localparam int SY_AVD = 3;
  localparam int SY_LOCK = 4;
  localparam int SY_W = 5;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_DELAY, ST_PLL, ST_FETCH0, ST_FETCH1, ST_RUN
  } seq_state_e;

endpackage

// *** hdl/dly_if.sv ***
// link between the sequencer and its delay counter
// assumes both ends run on the same cpu clock
`timescale 1ns/10ps
interface dly_if;
  import rsm_pkg::*;
  logic start;
  logic long_sel;
  logic abort;
  logic done;
  modport seq (output start, output long_sel, output abort, input done);
  modport cnt (input start, input long_sel, input abort, output done);
endinterface

// *** hdl/level_sync.sv ***
// two-flop synchronisers for asynchronous levels
// assumes inputs may change at any time relative to mclk_i
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;
  sync_s s_reg;
  sync_s s_next;

  // ==========================================================
  // per-bit stages
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_comb begin
      s_next.meta[g] = async_i[g];
      s_next.stable[g] = s_reg.meta[g];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stable;
endmodule

// *** hdl/delay_counter.sv ***
// internal reset delay counter, 256 or 4096 cycles
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/10ps
module delay_counter
  import rsm_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // sequencer side
  dly_if.cnt dl
);
  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic busy;
    logic done;
  } dly_s;
  dly_s s_reg;
  dly_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (dl.abort) begin
      s_next.busy = 1'b0;
    end else if (dl.start) begin
      s_next.busy = 1'b1;
      s_next.cnt = dl.long_sel ? DLY_W'(DELAY_LONG - 1)
                               : DLY_W'(DELAY_SHORT - 1);
    end else if (s_reg.busy) begin
      if (s_reg.cnt == '0) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - DLY_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dl.done = s_reg.done;
endmodule

// *** hdl/reset_sequence_supply_monitor.sv ***
// reset sequencer and supply integrity monitor
// assumes analog comparators and the reset pin are asynchronous,
// watchdog, opcode check and configuration run on mclk_i
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// How it works
// - pin, low-supply and watchdog causes merge
// - illegal opcode or prefix also resets
// - every cause drives pin; low during delay
// - vector fetched from FFFE then FFFF
// - active phase, delay, then vector fetch
// - delay 256 for rc/ext, 4096 crystal
// - vector fetch lasts exactly two cycles
// - multiplier adds start-up delay before clock
// - resonator keeps running during reset
// - external pin detected asynchronously, even halted
// - pin low while supply under threshold
// - watchdog pulse held minimum output duration
// - detector enable and level from configuration
// - aux comparator readable, read-only status bit
// - aux detector works only with detector enabled
// - aux threshold follows detector level selection
// - aux flag raises interrupt when enabled
// - trim is 8-bit register plus bits 6:5
// - irq needs enable and clear mask
// - halt freezes status register, aux inactive
// - two flags record last reset cause
module reset_sequence_supply_monitor
  import rsm_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // open-drain reset pin
  input wire logic rst_pin_in_i,
  output logic rst_pin_out_o,
  output logic rst_pin_oe_o,
  // reset causes
  input wire logic supply_below_lvd_i,
  input wire logic watchdog_underflow_i,
  input wire logic illegal_opcode_i,
  // configuration options
  input wire logic lvd_enable_i,
  input wire logic [1:0] lvd_level_i,
  input wire logic [1:0] clk_src_i,
  input wire logic pll_enable_i,
  // analog and clock status
  input wire logic supply_below_avd_i,
  input wire logic pll_locked_i,
  // core state
  input wire logic halt_i,
  input wire logic global_irq_mask_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // detector control
  output logic lvd_enable_o,
  output logic [1:0] lvd_level_o,
  output logic [1:0] avd_level_o,
  output logic [9:0] rc_calib_o,
  output logic osc_run_o,
  // core control
  output logic core_reset_o,
  output logic cpu_clk_run_o,
  output logic vector_fetch_o,
  output logic [15:0] vector_addr_o,
  output logic ext_reset_wake_o,
  output logic avd_irq_o,
  output logic avd_wake_o
);

  typedef struct packed {
    seq_state_e state;
    logic [PULSE_W-1:0] pulse_cnt;
    logic [PULSE_W-1:0] pll_cnt;
    logic [GUARD_W-1:0] guard;
    logic drive;
    logic [DATA_W-1:0] rc_trim;
    logic [1:0] trim_lo;
    logic watchdog_reset_flag;
    logic low_supply_reset_flag;
    logic aux_supply_low_flag;
    logic aux_supply_irq_enable;
    logic locked;
    logic [DATA_W-1:0] rdata;
    logic vec_fetch;
    logic [15:0] vec_addr;
    logic [1:0] lvd_level;
    logic lvd_en;
    logic irq;
    logic wake;
  } seq_s;
  seq_s s_reg;
  seq_s s_next;

  logic ext_latch;
  logic [SY_W-1:0] sy;
  logic lvd_act;
  logic int_cause;
  logic ext_act;
  logic any_cause;
  logic halted_regs;

  dly_if dl ();

  // ==========================================================
  // asynchronous capture of the reset pin
  // set by the pin itself so a halted clock still sees it
  always_ff @(posedge mclk_i or negedge rst_pin_in_i) begin
    if (!rst_pin_in_i) begin
      ext_latch <= 1'b1;
    end else if (!nrst_i) begin
      ext_latch <= 1'b0;
    end else if (sy[SY_PIN]) begin
      ext_latch <= 1'b0;
    end
  end

  level_sync #(.W(SY_W)) u_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i({pll_locked_i, supply_below_avd_i, supply_below_lvd_i,
              ext_latch, rst_pin_in_i}),
    .sync_o(sy)
  );

  delay_counter u_delay (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .dl(dl.cnt)
  );

  // ==========================================================
  // cause merge
  // own drive echoes back on the pin, so ignore it while the
  // guard runs; an external pulse shorter than the sync path
  // is still held by the latch
  assign lvd_act = lvd_enable_i & sy[SY_LVD];
  assign int_cause = watchdog_underflow_i | illegal_opcode_i;
  assign ext_act = sy[SY_LATCH] & ~s_reg.drive
                   & (s_reg.guard == '0);
  assign any_cause = lvd_act | int_cause | ext_act;
  assign halted_regs = halt_i;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = '0;
    dl.start = 1'b0;
    dl.long_sel = (clk_src_i == CLKSRC_XTAL);
    dl.abort = 1'b0;

    // ========================================================
    // minimum pulse for internal causes
    if (int_cause) begin
      s_next.pulse_cnt = PULSE_W'(WDG_PULSE_CYC);
    end else if (s_reg.pulse_cnt != '0) begin
      s_next.pulse_cnt = s_reg.pulse_cnt - PULSE_W'(1);
    end

    // ========================================================
    // sequencer
    case (s_reg.state)
      ST_ACTIVE: begin
        if (!lvd_act && !int_cause && s_reg.pulse_cnt == '0 &&
            s_reg.guard == '0 && !sy[SY_LATCH]) begin
          s_next.state = ST_DELAY;
          dl.start = 1'b1;
        end
      end
      ST_DELAY: begin
        if (dl.done) begin
          if (pll_enable_i) begin
            s_next.state = ST_PLL;
            s_next.pll_cnt = PULSE_W'(PLL_STARTUP_CYC - 1);
          end else begin
            s_next.state = ST_FETCH0;
          end
        end
      end
      ST_PLL: begin
        if (s_reg.pll_cnt == '0) begin
          s_next.state = ST_FETCH0;
        end else begin
          s_next.pll_cnt = s_reg.pll_cnt - PULSE_W'(1);
        end
      end
      ST_FETCH0: begin
        s_next.state = ST_FETCH1;
      end
      ST_FETCH1: begin
        s_next.state = ST_RUN;
      end
      ST_RUN: begin
        s_next.state = ST_RUN;
      end
      default: begin
        s_next.state = ST_ACTIVE;
      end
    endcase

    if (any_cause && s_reg.state != ST_ACTIVE) begin
      s_next.state = ST_ACTIVE;
      dl.abort = 1'b1;
    end

    // ========================================================
    // pin drive and echo guard
    s_next.drive = (s_next.state == ST_DELAY) |
                   ((s_next.state == ST_ACTIVE) &
                    (lvd_act | int_cause |
                     (s_next.pulse_cnt != '0)));
    if (s_reg.drive) begin
      s_next.guard = GUARD_W'(GUARD_CYC);
    end else if (s_reg.guard != '0) begin
      s_next.guard = s_reg.guard - GUARD_W'(1);
    end

    // ========================================================
    // vector fetch
    s_next.vec_fetch = (s_next.state == ST_FETCH0) |
                       (s_next.state == ST_FETCH1);
    s_next.vec_addr = (s_next.state == ST_FETCH1) ? VEC_ADDR_HI
                                                   : VEC_ADDR_LO;

    // ========================================================
    // register port; halt freezes the status register
    if (reg_wr_i && !halted_regs) begin
      if (reg_addr_i == ADDR_RC_TRIM) begin
        s_next.rc_trim = reg_wdata_i;
      end else if (reg_addr_i == ADDR_ICSR) begin
        s_next.trim_lo = reg_wdata_i[ICSR_TRIM_HI:ICSR_TRIM_LO];
        s_next.aux_supply_irq_enable = reg_wdata_i[ICSR_AUX_SUPPLY_IRQ_ENABLE];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_RC_TRIM) begin
        s_next.rdata = s_reg.rc_trim;
      end else if (reg_addr_i == ADDR_ICSR) begin
        s_next.rdata[ICSR_TRIM_HI:ICSR_TRIM_LO] = s_reg.trim_lo;
        s_next.rdata[ICSR_WATCHDOG_RESET_FLAG] = s_reg.watchdog_reset_flag;
        s_next.rdata[ICSR_LOCKED] = s_reg.locked;
        s_next.rdata[ICSR_LOW_SUPPLY_RESET_FLAG] = s_reg.low_supply_reset_flag;
        s_next.rdata[ICSR_AUX_SUPPLY_LOW_FLAG] = s_reg.aux_supply_low_flag;
        s_next.rdata[ICSR_AUX_SUPPLY_IRQ_ENABLE] = s_reg.aux_supply_irq_enable;
        if (!halted_regs) begin
          s_next.watchdog_reset_flag = 1'b0;
          s_next.low_supply_reset_flag = 1'b0;
        end
      end
    end

    // ========================================================
    // reset cause flags; a set beats a read clear
    if (ext_act && !int_cause && !lvd_act) begin
      s_next.watchdog_reset_flag = 1'b0;
      s_next.low_supply_reset_flag = 1'b0;
    end
    if (watchdog_underflow_i) begin
      s_next.watchdog_reset_flag = 1'b1;
    end
    if (lvd_act) begin
      s_next.low_supply_reset_flag = 1'b1;
      s_next.watchdog_reset_flag = 1'b0;
    end
    if (sy[SY_LOCK]) begin
      s_next.locked = 1'b1;
    end

    // ========================================================
    // auxiliary detector
    if (!halted_regs) begin
      s_next.aux_supply_low_flag = lvd_enable_i & sy[SY_AVD];
    end
    s_next.lvd_en = lvd_enable_i;
    s_next.lvd_level = lvd_level_i;
    s_next.irq = s_next.aux_supply_low_flag & s_next.aux_supply_irq_enable & ~global_irq_mask_i
                 & ~halted_regs;
    s_next.wake = s_next.aux_supply_low_flag & s_next.aux_supply_irq_enable & ~halted_regs;
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s_reg <= '0;
      s_reg.state <= ST_ACTIVE;
      s_reg.drive <= 1'b1;
      s_reg.rc_trim <= RC_TRIM_RST;
      s_reg.trim_lo <= ICSR_TRIM_RST;
      s_reg.vec_addr <= VEC_ADDR_LO;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign rst_pin_out_o = 1'b0;
  assign rst_pin_oe_o = s_reg.drive;
  assign reg_rdata_o = s_reg.rdata;
  assign lvd_enable_o = s_reg.lvd_en;
  assign lvd_level_o = s_reg.lvd_level;
  assign avd_level_o = s_reg.lvd_level;
  assign rc_calib_o = {s_reg.rc_trim, s_reg.trim_lo};
  assign osc_run_o = 1'b1;
  assign core_reset_o = (s_reg.state != ST_RUN);
  assign cpu_clk_run_o = (s_reg.state != ST_PLL);
  assign vector_fetch_o = s_reg.vec_fetch;
  assign vector_addr_o = s_reg.vec_addr;
  assign ext_reset_wake_o = ext_latch;
  assign avd_irq_o = s_reg.irq;
  assign avd_wake_o = s_reg.wake;
endmodule

// *** dv/rsm_monitor.sv ***
// timing checks on the reset sequencer's top ports
// assumes a bind from the bench top; one clock, sync reset
`timescale 1ns/10ps
module rsm_monitor (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // causes and configuration
  input wire logic supply_below_lvd_i,
  input wire logic watchdog_underflow_i,
  input wire logic illegal_opcode_i,
  input wire logic lvd_enable_i,
  input wire logic [1:0] lvd_level_i,
  input wire logic pll_enable_i,
  input wire logic halt_i,
  input wire logic global_irq_mask_i,
  // observed outputs
  input wire logic rst_pin_oe_o,
  input wire logic lvd_enable_o,
  input wire logic [1:0] lvd_level_o,
  input wire logic [1:0] avd_level_o,
  input wire logic core_reset_o,
  input wire logic vector_fetch_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic avd_irq_o,
  input wire logic avd_wake_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================================
  // sequence
  a_fetch_lo: assert property ($rose(vector_fetch_o) |->
    vector_addr_o == 16'hFFFE) else $error("first fetch address wrong");
  a_fetch_hi: assert property ($rose(vector_fetch_o) |=>
    vector_addr_o == 16'hFFFF) else $error("second fetch address wrong");
  a_fetch_two: assert property ($rose(vector_fetch_o) |=>
    vector_fetch_o ##1 !vector_fetch_o) else $error("fetch not 2 cycles");
  a_delay_pin: assert property ($rose(vector_fetch_o) && !pll_enable_i
    |-> $past(rst_pin_oe_o)) else $error("pin released before fetch");
  a_run_after: assert property ($fell(vector_fetch_o) && !rst_pin_oe_o
    |-> !core_reset_o) else $error("core held after fetch");
  a_wdg_pulse: assert property (watchdog_underflow_i |=>
    rst_pin_oe_o [*8]) else $error("watchdog pin pulse short");
  a_bad_opcode: assert property (illegal_opcode_i |=>
    core_reset_o && rst_pin_oe_o) else $error("opcode reset missing");
  a_lvd_pin: assert property ((supply_below_lvd_i && lvd_enable_i) [*5]
    |-> rst_pin_oe_o) else $error("pin free under low supply");
  // ==========================================================
  // detectors
  a_cfg_follow: assert property ($past(nrst_i) |->
    lvd_level_o == $past(lvd_level_i) && lvd_enable_o == $past(lvd_enable_i))
    else $error("detector config not followed");
  a_aux_level: assert property (avd_level_o == lvd_level_o)
    else $error("aux level differs");
  a_aux_off: assert property (!lvd_enable_i [*4] |->
    !avd_irq_o && !avd_wake_o) else $error("aux active while disabled");
  a_irq_mask: assert property (avd_irq_o |-> avd_wake_o &&
    !$past(global_irq_mask_i)) else $error("irq despite mask");
  a_halt_quiet: assert property (avd_wake_o |-> !$past(halt_i))
    else $error("aux wake in halt");
  c_fetch: cover property ($rose(vector_fetch_o));
  c_irq: cover property ($rose(avd_irq_o));
  c_wdg: cover property (watchdog_underflow_i);
endmodule

// *** dv/pin_partner.sv ***
// external reset circuitry on the open-drain reset pin
// assumes a pull-up on the pin, so released reads high
`timescale 1ns/10ps
module pin_partner (
  // clock
  input wire logic mclk_i,
  // pull-down request
  output logic pull_o
);
  initial pull_o = 1'b0;
  // holds the pin low whole cycles, well above minimum width
  task automatic press(input int n);
    @(posedge mclk_i);
    pull_o <= 1'b1;
    repeat (n) @(posedge mclk_i);
    pull_o <= 1'b0;
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench of the reset sequencer
// assumes rsm_pkg compiled first; pin has a pull-up
`timescale 1ns/10ps
module testbench
  import rsm_pkg::*;
;
  logic mclk_i, nrst_i, supply_below_lvd_i, watchdog_underflow_i;
  logic illegal_opcode_i, lvd_enable_i, pll_enable_i, supply_below_avd_i;
  logic pll_locked_i, halt_i, global_irq_mask_i, reg_wr_i, reg_rd_i;
  logic [1:0] lvd_level_i, clk_src_i, lvd_level_o, avd_level_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic rst_pin_out_o, rst_pin_oe_o, lvd_enable_o, osc_run_o, core_reset_o;
  logic cpu_clk_run_o, vector_fetch_o, ext_reset_wake_o, avd_irq_o;
  logic avd_wake_o, pull;
  logic [9:0] rc_calib_o;
  logic [15:0] vector_addr_o;
  wire rst_pin;
  int mismatches, n_checks, dly, tot, stp;
  assign rst_pin = !(rst_pin_oe_o | pull);
  reset_sequence_supply_monitor dut (.mclk_i, .nrst_i,
    .rst_pin_in_i(rst_pin), .rst_pin_out_o, .rst_pin_oe_o,
    .supply_below_lvd_i, .watchdog_underflow_i, .illegal_opcode_i,
    .lvd_enable_i, .lvd_level_i, .clk_src_i, .pll_enable_i,
    .supply_below_avd_i, .pll_locked_i, .halt_i, .global_irq_mask_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .lvd_enable_o, .lvd_level_o, .avd_level_o, .rc_calib_o, .osc_run_o,
    .core_reset_o, .cpu_clk_run_o, .vector_fetch_o, .vector_addr_o,
    .ext_reset_wake_o, .avd_irq_o, .avd_wake_o);
  pin_partner u_pin (.mclk_i, .pull_o(pull));
  // ==========================================================
  // tasks
  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask
  task automatic kick(input bit wdg);
    @(posedge mclk_i);
    watchdog_underflow_i <= wdg;
    illegal_opcode_i <= !wdg;
    @(posedge mclk_i);
    watchdog_underflow_i <= 1'b0;
    illegal_opcode_i <= 1'b0;
    #1;
  endtask
  // waits for the fetch; dly is the last pin-low stretch
  task automatic run_seq(input int exp);
    dly = 0;
    tot = 0;
    stp = 0;
    while (!vector_fetch_o && tot < 12000) begin
      @(posedge mclk_i);
      #1;
      tot++;
      if (!cpu_clk_run_o) stp++;
      if (!vector_fetch_o) dly = rst_pin_oe_o ? dly + 1 : 0;
    end
    chk("vec_lo", vector_addr_o, VEC_ADDR_LO);
    @(posedge mclk_i);
    #1;
    chk("vec_hi", vector_addr_o, VEC_ADDR_HI);
    @(posedge mclk_i);
    #1;
    chk("run", {vector_fetch_o, core_reset_o}, 16'h0);
    if (exp > 0) chk("delay", 16'(dly >= exp && dly <= exp + 3), 16'h1);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and tests
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = !mclk_i;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    {nrst_i, watchdog_underflow_i, illegal_opcode_i, halt_i} = 4'h0;
    {supply_below_lvd_i, supply_below_avd_i, pll_enable_i} = 3'h0;
    {global_irq_mask_i, reg_wr_i, reg_rd_i} = 3'h0;
    {lvd_enable_i, pll_locked_i, lvd_level_i} = 4'hD;
    {reg_addr_i, reg_wdata_i} = 16'h0;
    clk_src_i = CLKSRC_RC;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    run_seq(DELAY_SHORT);
    rd(ADDR_RC_TRIM);
    chk("trim_rst", d, RC_TRIM_RST);
    rd(ADDR_ICSR);
    chk("icsr_trim", d[6:5], ICSR_TRIM_RST);
    wr(ADDR_RC_TRIM, 8'h5A);
    wr(ADDR_ICSR, 8'h21);
    @(negedge mclk_i);
    chk("calib", rc_calib_o, 16'h169);
    rd(8'h7F);
    chk("unmapped", d, 8'h00);
    kick(1);
    run_seq(DELAY_SHORT);
    fork
      u_pin.press(20);
      begin
        repeat (8) @(posedge mclk_i);
        #1;
        chk("pin_wake", ext_reset_wake_o, 16'h1);
      end
    join
    run_seq(DELAY_SHORT);
    rd(ADDR_ICSR);
    chk("pin_flags", {d[ICSR_WATCHDOG_RESET_FLAG], d[ICSR_LOW_SUPPLY_RESET_FLAG]}, 16'h0);
    kick(1);
    chk("osc", osc_run_o, 16'h1);
    chk("pin_out", rst_pin_out_o, 16'h0);
    run_seq(DELAY_SHORT);
    rd(ADDR_ICSR);
    chk("wdg_flags", {d[ICSR_WATCHDOG_RESET_FLAG], d[ICSR_LOW_SUPPLY_RESET_FLAG]}, 16'h2);
    rd(ADDR_ICSR);
    chk("wdg_clr", d[ICSR_WATCHDOG_RESET_FLAG], 16'h0);
    supply_below_lvd_i <= 1'b1;
    repeat (30) @(posedge mclk_i);
    #1;
    chk("lvd_pin", rst_pin, 16'h0);
    @(posedge mclk_i);
    supply_below_lvd_i <= 1'b0;
    run_seq(DELAY_SHORT);
    rd(ADDR_ICSR);
    chk("lvd_flag", d[ICSR_LOW_SUPPLY_RESET_FLAG], 16'h1);
    supply_below_avd_i <= 1'b1;
    lvd_level_i <= 2'h2;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("irq", avd_irq_o, 16'h1);
    chk("levels", {avd_level_o, lvd_level_o}, 16'hA);
    rd(ADDR_ICSR);
    chk("aux_supply_low_flag", d[ICSR_AUX_SUPPLY_LOW_FLAG], 16'h1);
    global_irq_mask_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk("masked", {avd_irq_o, avd_wake_o}, 16'h1);
    halt_i <= 1'b1;
    wr(ADDR_ICSR, 8'h02);
    #1;
    chk("halt_wake", avd_wake_o, 16'h0);
    halt_i <= 1'b0;
    rd(ADDR_ICSR);
    chk("frozen", d[ICSR_AUX_SUPPLY_IRQ_ENABLE], 16'h1);
    lvd_enable_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1;
    chk("aux_off", avd_wake_o, 16'h0);
    {lvd_enable_i, supply_below_avd_i, global_irq_mask_i} <= 3'h4;
    clk_src_i <= CLKSRC_XTAL;
    kick(0);
    chk("opcode", core_reset_o, 16'h1);
    repeat (1400) @(posedge mclk_i);
    #1;
    chk("in_delay", {core_reset_o, rst_pin_oe_o}, 16'h3);
    kick(0);
    run_seq(DELAY_LONG);
    chk("restart", 16'(tot > DELAY_LONG), 16'h1);
    clk_src_i <= CLKSRC_EXT;
    pll_enable_i <= 1'b1;
    kick(0);
    run_seq(0);
    chk("pll_wait", 16'(stp >= PLL_STARTUP_CYC), 16'h1);
    finish_test();
  end
endmodule
bind reset_sequence_supply_monitor rsm_monitor u_mon (.mclk_i, .nrst_i,
  .supply_below_lvd_i, .watchdog_underflow_i, .illegal_opcode_i,
  .lvd_enable_i, .lvd_level_i, .pll_enable_i, .halt_i, .global_irq_mask_i,
  .rst_pin_oe_o, .lvd_enable_o, .lvd_level_o, .avd_level_o, .core_reset_o,
  .vector_fetch_o, .vector_addr_o, .avd_irq_o, .avd_wake_o);
